// ==== core/double_speed_clock_select.sv ====
// Clock speed selector: divide-by-two stage, double-speed switch and
// per-peripheral speed selection, with its control registers on APB.
// Assumes the oscillator arrives asynchronously on a pin and is slow
// against the system clock (at most a quarter of it), and that the
// security byte's double-speed bit is stable while reset is held.
// Limitation: in double speed each tick follows the pin directly, so uneven
// pin periods show up as uneven tick spacing.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module double_speed_clock_select #(
	parameter int unsigned N_PERIPH = clk_speed_pkg::N_PERIPH,
	parameter int unsigned TICKS    = clk_speed_pkg::TICKS_PER_CYCLE
) (
	input  wire logic                 clk_sys_in,
	input  wire logic                 reset_n_in,
	input  wire logic                 security_double_speed_in,
	input  wire logic                 primary_osc_input_in,
	input  wire logic [1:0]           uart_mode_in,
	input  wire logic [11:0]          paddr_in,
	input  wire logic                 psel_in,
	input  wire logic                 penable_in,
	input  wire logic                 pwrite_in,
	input  wire logic [31:0]          pwdata_in,
	output logic      [31:0]          prdata_out,
	output logic                      pready_out,
	output logic                      pslverr_out,
	output logic                      osc_div2_out,
	output logic                      cpu_double_speed_out,
	output logic                      cpu_phase_tick_out,
	output logic                      cpu_machine_cycle_out,
	output logic      [N_PERIPH-1:0]  periph_tick_out,
	output logic      [N_PERIPH-1:0]  periph_cycle_out
);

	// Address decode, shared by the read path and the write/error path
	function automatic clk_speed_pkg::reg_sel_t decode(
		input logic [11:0] addr
	);
		clk_speed_pkg::reg_sel_t sel;
		sel = clk_speed_pkg::SEL_NONE;
		case (addr)
			clk_speed_pkg::ADDR_MAIN: begin
				sel = clk_speed_pkg::SEL_MAIN;
			end
			clk_speed_pkg::ADDR_AUX: begin
				sel = clk_speed_pkg::SEL_AUX;
			end
			clk_speed_pkg::ADDR_STATUS: begin
				sel = clk_speed_pkg::SEL_STATUS;
			end
			default: begin
				sel = clk_speed_pkg::SEL_NONE;
			end
		endcase
		return sel;
	endfunction : decode

	// Lane speed decode, shared by the live update and the reset value
	function automatic logic lane_fast(
		input logic        dbl,
		input logic        slow_bit,
		input logic [1:0]  mode,
		input int unsigned lane
	);
		logic fast;
		fast = dbl && !slow_bit;
		if (lane == clk_speed_pkg::P_UART) begin
			// Modes 1 and 3 keep standard timing on the serial lane
			fast = fast && (mode == clk_speed_pkg::UART_MODE0
				|| mode == clk_speed_pkg::UART_MODE2);
		end
		return fast;
	endfunction : lane_fast

	// Oscillator pin synchroniser and edge detection
	logic osc_meta_q;
	logic osc_sync_q;
	logic osc_prev_q;
	logic osc_rise;

	// Divide-by-two stage and the mode it gates
	logic div2_q;
	logic div2_rise;

	// Software control bits
	logic                cpu_double_speed_q;
	logic [N_PERIPH-1:0] speed_sel_q;

	// Effective speed, updated only at divided-clock rising edges
	logic                double_active_q;
	logic [N_PERIPH-1:0] fast_active_q;
	logic [N_PERIPH-1:0] fast_next;
	logic [N_PERIPH-1:0] fast_reset;

	// Registered tick pulses
	logic                cpu_tick_q;
	logic [N_PERIPH-1:0] periph_tick_q;

	// Bus side
	clk_speed_pkg::reg_sel_t sel;
	logic                    setup;
	logic                    access;
	logic                    wr_en;
	logic [31:0]             rd_mux;
	logic [31:0]             prdata_q;

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			osc_meta_q <= 1'h0;
			osc_sync_q <= 1'h0;
			osc_prev_q <= 1'h0;
		end else begin
			osc_meta_q <= primary_osc_input_in;
			osc_sync_q <= osc_meta_q;
			osc_prev_q <= osc_sync_q;
		end
	end

	// Only the edge detector reads the third flop; the first feeds nothing
	// but the second, so metastability stays out of the logic
	assign osc_rise = osc_sync_q && !osc_prev_q;

	// Toggle on every oscillator rising edge gives the divided clock
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			div2_q <= 1'h0;
		end else if (osc_rise) begin
			div2_q <= !div2_q;
		end
	end

	assign div2_rise = osc_rise && !div2_q;

	// Register writes
	assign setup  = psel_in && !penable_in;
	assign access = psel_in && penable_in;
	assign sel    = decode(paddr_in);
	assign wr_en  = access && pwrite_in;

	// Strap is same-clock flash data, caught while reset is held
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			cpu_double_speed_q <= security_double_speed_in;
		end else if (wr_en && sel == clk_speed_pkg::SEL_MAIN) begin
			cpu_double_speed_q <=
				pwdata_in[clk_speed_pkg::BIT_CPU_DS];
		end
	end

	// Main register bits 7..1 fill lanes 6..0; the SPI lane is the aux bit
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			speed_sel_q[clk_speed_pkg::P_SPI-1:0] <=
				clk_speed_pkg::MAIN_PERIPH_RST;
		end else if (wr_en && sel == clk_speed_pkg::SEL_MAIN) begin
			speed_sel_q[clk_speed_pkg::P_SPI-1:0] <=
				pwdata_in[clk_speed_pkg::BIT_TWOWIRE:
					clk_speed_pkg::BIT_TIMER0];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			speed_sel_q[clk_speed_pkg::P_SPI] <=
				clk_speed_pkg::AUX_SPI_RST;
		end else if (wr_en && sel == clk_speed_pkg::SEL_AUX) begin
			speed_sel_q[clk_speed_pkg::P_SPI] <=
				pwdata_in[clk_speed_pkg::BIT_SPI];
		end
	end

	// Which lanes would run fast from the next divided-clock edge, and
	// which run fast straight out of reset, when select bits are clear
	generate
		for (genvar i = 0; i < N_PERIPH; i++) begin : g_fast
			assign fast_next[i]  = lane_fast(cpu_double_speed_q,
				speed_sel_q[i], uart_mode_in, i);
			assign fast_reset[i] = lane_fast(security_double_speed_in,
				1'h0, uart_mode_in, i);
		end
	endgenerate

	// Mode switch only at a divided-clock rising edge, so no tick is cut
	// short when leaving double speed
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			double_active_q <= security_double_speed_in;
		end else if (div2_rise) begin
			double_active_q <= cpu_double_speed_q;
		end
	end

	// Lanes start in step with the strapped core speed, the serial lane only in modes 0 and 2
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			fast_active_q <= fast_reset;
		end else if (div2_rise) begin
			fast_active_q <= fast_next;
		end
	end

	// Double speed bypasses the divider: one tick per oscillator period
	// Standard mode ticks at the divided rate, twelve pin periods a cycle
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			cpu_tick_q <= 1'h0;
		end else begin
			cpu_tick_q <= double_active_q ? osc_rise : div2_rise;
		end
	end

	generate
		for (genvar i = 0; i < N_PERIPH; i++) begin : g_tick
			always_ff @(posedge clk_sys_in) begin
				if (!reset_n_in) begin
					periph_tick_q[i] <= 1'h0;
				end else begin
					periph_tick_q[i] <= fast_active_q[i] ? osc_rise
						: div2_rise;
				end
			end

			cycle_counter #(
				.TICKS      (TICKS)
			) u_periph_cycle (
				.clk_sys_in (clk_sys_in),
				.reset_n_in (reset_n_in),
				.tick_in    (periph_tick_q[i]),
				.cycle_out  (periph_cycle_out[i])
			);
		end
	endgenerate

	// Six ticks per machine cycle: six or twelve oscillator periods
	cycle_counter #(
		.TICKS      (TICKS)
	) u_cpu_cycle (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.tick_in    (cpu_tick_q),
		.cycle_out  (cpu_machine_cycle_out)
	);

	// Read mux; reserved bits read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (sel)
			clk_speed_pkg::SEL_MAIN: begin
				rd_mux[clk_speed_pkg::BIT_CPU_DS] = cpu_double_speed_q;
				rd_mux[clk_speed_pkg::BIT_TWOWIRE:
					clk_speed_pkg::BIT_TIMER0] =
					speed_sel_q[clk_speed_pkg::P_SPI-1:0];
			end
			clk_speed_pkg::SEL_AUX: begin
				rd_mux[clk_speed_pkg::BIT_SPI] =
					speed_sel_q[clk_speed_pkg::P_SPI];
			end
			clk_speed_pkg::SEL_STATUS: begin
				// Effective speeds lag the control bits until the next
				// divided-clock rising edge
				rd_mux[clk_speed_pkg::BIT_ST_DS] = double_active_q;
				rd_mux[clk_speed_pkg::BIT_ST_FAST +: N_PERIPH] =
					fast_active_q;
				rd_mux[clk_speed_pkg::BIT_ST_DIV2] = div2_q;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Captured in the setup cycle so the access phase sees a flop
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup && !pwrite_in) begin
			prdata_q <= rd_mux;
		end
	end

	assign prdata_out            = prdata_q;
	assign pready_out            = 1'h1;
	// Status writes are dropped without error; only unmapped offsets fail
	assign pslverr_out           = access && sel == clk_speed_pkg::SEL_NONE;
	assign osc_div2_out          = div2_q;
	assign cpu_double_speed_out  = double_active_q;
	assign cpu_phase_tick_out    = cpu_tick_q;
	assign periph_tick_out       = periph_tick_q;

endmodule : double_speed_clock_select

// ==== common/clk_speed_pkg.sv ====
// Constants, register map and decode types for the clock speed selector.
// Assumes a 32-bit APB slave and one system clock; no other dependency.
package clk_speed_pkg;

	// Register indices as printed; the APB byte address is four times these
	localparam logic [7:0]  IDX_MAIN      = 8'h8f;
	localparam logic [7:0]  IDX_AUX       = 8'haf;
	localparam logic [7:0]  IDX_STATUS    = 8'hb0;
	localparam int unsigned ADDR_W        = 12;
	localparam int unsigned DATA_W        = 32;
	localparam logic [11:0] ADDR_MAIN     = {2'h0, IDX_MAIN, 2'h0};
	localparam logic [11:0] ADDR_AUX      = {2'h0, IDX_AUX, 2'h0};
	localparam logic [11:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};

	// Main control register fields
	localparam int unsigned BIT_CPU_DS    = 0;
	localparam int unsigned BIT_TIMER0    = 1;
	localparam int unsigned BIT_TIMER1    = 2;
	localparam int unsigned BIT_TIMER2    = 3;
	localparam int unsigned BIT_UART      = 4;
	localparam int unsigned BIT_CNT_ARRAY = 5;
	localparam int unsigned BIT_WATCHDOG  = 6;
	localparam int unsigned BIT_TWOWIRE   = 7;
	// Auxiliary control register field
	localparam int unsigned BIT_SPI       = 0;
	// Status register fields
	localparam int unsigned BIT_ST_DS     = 0;
	localparam int unsigned BIT_ST_FAST   = 1;
	localparam int unsigned BIT_ST_DIV2   = 9;

	// Peripheral clock lanes
	localparam int unsigned N_PERIPH      = 8;
	localparam int unsigned P_TIMER0      = 0;
	localparam int unsigned P_UART        = 3;
	localparam int unsigned P_SPI         = 7;

	// Reset values
	localparam logic [6:0]  MAIN_PERIPH_RST = 7'h00;
	localparam logic        AUX_SPI_RST     = 1'h0;

	// Timing in oscillator periods
	localparam int unsigned OSC_DIV           = 2;
	localparam int unsigned FAST_OSC_PER_CYCLE = 6;
	localparam int unsigned SLOW_OSC_PER_CYCLE = 12;
	// Phase ticks per machine cycle; a fast tick is one oscillator period
	localparam int unsigned TICKS_PER_CYCLE    = FAST_OSC_PER_CYCLE;

	// Serial modes in which the serial speed bit applies
	localparam logic [1:0]  UART_MODE0    = 2'h0;
	localparam logic [1:0]  UART_MODE2    = 2'h2;

	typedef enum logic [3:0] {
		SEL_NONE   = 4'h1,
		SEL_MAIN   = 4'h2,
		SEL_AUX    = 4'h4,
		SEL_STATUS = 4'h8
	} reg_sel_t;

endpackage : clk_speed_pkg

// ==== core/cycle_counter.sv ====
// Counts phase ticks and pulses once per completed cycle.
// Assumes tick_in is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps
module cycle_counter #(
	parameter int unsigned TICKS = 6
) (
	input  wire logic clk_sys_in,
	input  wire logic reset_n_in,
	input  wire logic tick_in,
	output logic      cycle_out
);

	localparam int unsigned CNT_W = $clog2(TICKS + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(TICKS - 1);

	logic [CNT_W-1:0] count_q;
	logic             cycle_q;

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			count_q <= '0;
		end else if (tick_in) begin
			if (count_q == LAST) begin
				count_q <= '0;
			end else begin
				count_q <= count_q + CNT_W'(1);
			end
		end
	end

	// Pulse registered so the cycle edge lines up one clock after its tick
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			cycle_q <= 1'h0;
		end else begin
			cycle_q <= tick_in && (count_q == LAST);
		end
	end

	assign cycle_out = cycle_q;

endmodule : cycle_counter

// ==== tb/double_speed_clock_select_sva.sv ====
// Timing checks on the clock speed selector's ports.
// Assumes one clock domain and an oscillator much slower than the clock.
`timescale 1ns/100ps
module clock_select_sva #(
	parameter int unsigned N_PERIPH = 8,
	parameter int unsigned TICKS    = 6
) (
	input wire logic                clk_sys_in,
	input wire logic                reset_n_in,
	input wire logic                security_double_speed_in,
	input wire logic [1:0]          uart_mode_in,
	input wire logic                psel_in,
	input wire logic                penable_in,
	input wire logic                pslverr_out,
	input wire logic                osc_div2_out,
	input wire logic                cpu_double_speed_out,
	input wire logic                cpu_phase_tick_out,
	input wire logic                cpu_machine_cycle_out,
	input wire logic [N_PERIPH-1:0] periph_tick_out
);
	logic [1:0] ntog_q;
	logic [3:0] tcnt_q;
	logic       ok_q, mode_q, ds_q;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	always_ff @(posedge clk_sys_in) begin
		ds_q <= cpu_double_speed_out;
	end
	// Divided-clock toggles strictly between two core ticks; the toggle
	// launched with a tick shows up at the same edge as that tick
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			ntog_q <= 2'h0;
			ok_q   <= 1'b0;
			mode_q <= 1'b0;
		end else if (cpu_phase_tick_out) begin
			ntog_q <= 2'h0;
			ok_q   <= 1'b1;
			mode_q <= cpu_double_speed_out;
		end else if ($changed(osc_div2_out)) begin
			ntog_q <= ntog_q + 2'h1;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in || cpu_machine_cycle_out)
			tcnt_q <= 4'h0;
		else if (cpu_phase_tick_out)
			tcnt_q <= tcnt_q + 4'h1;
	end
	ds_switch_a: assert property ($changed(cpu_double_speed_out) |-> osc_div2_out)
		else $error("speed mode changed off a divided-clock rise");
	tick_rate_a: assert property (cpu_phase_tick_out && ok_q &&
		mode_q == cpu_double_speed_out |-> ntog_q == (mode_q ? 2'h0 : 2'h1))
		else $error("core tick spacing wrong for speed mode");
	mcycle_count_a: assert property (cpu_machine_cycle_out == (tcnt_q == 4'(TICKS)))
		else $error("machine cycle not after six ticks");
	slow_lanes_a: assert property (!cpu_double_speed_out && !ds_q |->
		periph_tick_out == {N_PERIPH{cpu_phase_tick_out}})
		else $error("lane ticks differ from core in standard mode");
	lane_subset_a: assert property ((periph_tick_out &
		~{N_PERIPH{cpu_phase_tick_out}}) == '0)
		else $error("lane ticked without a core tick");
	uart_slow_a: assert property (cpu_double_speed_out && uart_mode_in[0]
		&& periph_tick_out[3] |-> osc_div2_out)
		else $error("serial lane fast outside modes 0 and 2");
	reset_mode_a: assert property ($rose(reset_n_in) |->
		cpu_double_speed_out == $past(security_double_speed_in))
		else $error("reset speed mode not from security byte");
	err_access_a: assert property (pslverr_out |-> psel_in && penable_in)
		else $error("error flagged outside an access phase");
endmodule : clock_select_sva
bind double_speed_clock_select clock_select_sva #(.N_PERIPH(N_PERIPH),
	.TICKS(TICKS)) i_sva (.clk_sys_in, .reset_n_in,
	.security_double_speed_in, .uart_mode_in, .psel_in, .penable_in,
	.pslverr_out, .osc_div2_out, .cpu_double_speed_out,
	.cpu_phase_tick_out, .cpu_machine_cycle_out, .periph_tick_out);

// ==== tb/test_double_speed_clock_select.sv ====
// Self-checking bench: register access and measured cycle lengths.
// Assumes zero-wait APB and an oscillator of six clock periods.
`timescale 1ns/100ps
module test_double_speed_clock_select;
	logic        clk_sys_in, reset_n_in, sec, osc, psel, pen, pwr;
	logic [1:0]  um;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, s, st;
	logic        pready, perr, e;
	logic [7:0]  mv, pt, pc, fm;
	logic        av, mc;
	int          n_mismatch, checked, cyc, oc, n;
	double_speed_clock_select i_dut (.clk_sys_in, .reset_n_in,
		.security_double_speed_in(sec), .primary_osc_input_in(osc),
		.uart_mode_in(um), .paddr_in(paddr), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
		.osc_div2_out(), .cpu_double_speed_out(), .cpu_phase_tick_out(),
		.cpu_machine_cycle_out(mc), .periph_tick_out(pt),
		.periph_cycle_out(pc));
	always #5 clk_sys_in = ~clk_sys_in;
	// Oscillator of six clock periods, high and low three each
	always @(posedge clk_sys_in) begin
		oc <= (oc == 2) ? 0 : oc + 1;
		if (oc == 2)
			osc <= ~osc;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			conclude();
		end
	end
	function logic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction : rnd
	// Expected machine or lane cycle length in clock periods
	function int ex(logic ds, logic b, int l, logic [1:0] m);
		return (ds && !b && !(l == 3 && m[0])) ? 36 : 72;
	endfunction : ex
	function logic pl(int l);
		return (l == 8) ? mc : pc[l];
	endfunction : pl
	task chk(string nm, logic [31:0] x, logic [31:0] g);
		checked++;
		if (x !== g) begin
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
			n_mismatch++;
		end
	endtask : chk
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge clk_sys_in);
		psel   <= 1'b1;
		pen    <= 1'b0;
		paddr  <= a;
		pwr    <= w;
		pwdata <= d;
		@(posedge clk_sys_in);
		pen <= 1'b1;
		do @(posedge clk_sys_in); while (pready !== 1'b1);
		r = prdata;
		e = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb
	// Clock periods between two successive cycle pulses
	task per(int l);
		int k;
		k = 0;
		do begin @(posedge clk_sys_in); k++; end while (pl(l) !== 1'b1 && k < 400);
		n = 0;
		do begin @(posedge clk_sys_in); n++; end while (pl(l) !== 1'b1 && n < 400);
	endtask : per
	task conclude();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	initial begin
		{clk_sys_in, reset_n_in, sec, osc, psel, pen, pwr} = 7'h0;
		{um, paddr, pwdata} = 46'h0;
		{n_mismatch, checked, cyc, oc} = 0;
		st = 32'h964e;
		for (int h = 1; h >= 0; h--) begin
			sec        <= h[0];
			reset_n_in <= 1'b0;
			repeat (6) @(posedge clk_sys_in);
			reset_n_in <= 1'b1;
			apb(1'b0, clk_speed_pkg::ADDR_MAIN, 32'h0);
			chk("main reset", {31'h0, h[0]}, r);
			apb(1'b0, clk_speed_pkg::ADDR_AUX, 32'h0);
			chk("aux reset", 32'h0, r & 32'h1);
		end
		apb(1'b0, 12'h004, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			s  = rnd();
			mv = (i == 0) ? 8'h01 : (i == 1) ? 8'hff : (i == 2) ? 8'hfe : s[7:0];
			av = (i == 1) ? 1'b1 : s[8];
			// Serial mode moves only while standard speed is in force
			apb(1'b1, clk_speed_pkg::ADDR_MAIN, 32'h0);
			repeat (30) @(posedge clk_sys_in);
			um <= (i == 3) ? 2'h1 : s[10:9];
			apb(1'b1, clk_speed_pkg::ADDR_MAIN, {s[31:8], mv});
			apb(1'b1, clk_speed_pkg::ADDR_AUX, {s[31:1], av});
			apb(1'b0, clk_speed_pkg::ADDR_MAIN, 32'h0);
			chk("main readback", {24'h0, mv}, r);
			apb(1'b0, clk_speed_pkg::ADDR_AUX, 32'h0);
			chk("aux readback", {31'h0, av}, r);
			repeat (150) @(posedge clk_sys_in);
			per(8);
			chk("cpu period", ex(mv[0], 1'b0, 8, um), n);
			for (int l = 0; l < 8; l++) begin
				per(l);
				fm[l] = ex(mv[0], (l < 7) ? mv[l+1] : av, l, um) == 36;
				chk("lane period", ex(mv[0], (l < 7) ? mv[l+1] : av, l, um), n);
			end
			// Effective speeds as seen by software, divided clock masked
			apb(1'b0, clk_speed_pkg::ADDR_STATUS, 32'h0);
			chk("status speeds", {23'h0, fm, mv[0]}, r & 32'h1ff);
		end
		$display("test speed done");
		conclude();
	end
endmodule : test_double_speed_clock_select
